// ===== hdl/pcgc_pkg.sv
package pcgc_pkg;

    // Peripheral indices: converter, 8 GPIO, hibernation, 2 I2C, PWM,
    // 2 SSI, 4 timers, 3 UARTs, DMA, watchdog.
    localparam int unsigned NUM_PERIPH = 25;
    localparam int unsigned SEL_W      = 5;

    localparam logic [SEL_W-1:0] CONVERTER_UNIT_SELECT   = 5'h00;
    localparam logic [SEL_W-1:0] GPIO_FIRST_SELECT       = 5'h01;
    localparam logic [SEL_W-1:0] HIBERNATION_UNIT_SELECT = 5'h09;
    localparam logic [SEL_W-1:0] I2C_FIRST_SELECT        = 5'h0A;
    localparam logic [SEL_W-1:0] PWM_UNIT_SELECT         = 5'h0C;
    localparam logic [SEL_W-1:0] SSI_FIRST_SELECT        = 5'h0D;
    localparam logic [SEL_W-1:0] TIMER_FIRST_SELECT      = 5'h0F;
    localparam logic [SEL_W-1:0] UART_FIRST_SELECT       = 5'h13;
    localparam logic [SEL_W-1:0] DMA_CONTROLLER_SELECT   = 5'h16;
    localparam logic [SEL_W-1:0] WATCHDOG_UNIT_SELECT    = 5'h17;
    localparam logic [SEL_W-1:0] LAST_SELECT             = 5'h18;

    // Clock rate and enable latency.
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned EN_LAT_CYCLES  = 5;
    localparam int unsigned LAT_W          = 3;
    localparam logic [LAT_W-1:0] LAT_LOAD  = 3'h5;
    localparam logic [LAT_W-1:0] LAT_ZERO  = 3'h0;
    localparam logic [LAT_W-1:0] LAT_ONE   = 3'h1;

    // Width of the software reset pulse in clock cycles.
    localparam int unsigned SRST_W         = 2;
    localparam logic [SRST_W-1:0] SRST_LOAD = 2'h2;
    localparam logic [SRST_W-1:0] SRST_ZERO = 2'h0;
    localparam logic [SRST_W-1:0] SRST_ONE  = 2'h1;

    // Presence pattern of this variant; all listed peripherals fitted.
    localparam logic [NUM_PERIPH-1:0] PRESENT_MASK = 25'h1FFFFFF;
    localparam logic [NUM_PERIPH-1:0] ALL_ZERO     = 25'h0000000;

    typedef struct packed {
        logic             run_set;
        logic             run_clr;
        logic             dsleep_set;
        logic             dsleep_clr;
        logic             sw_reset;
        logic [SEL_W-1:0] sel;
    } pcgc_cmd_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [SEL_W-1:0] sel;
    } pcgc_acc_t;

endpackage : pcgc_pkg

// ===== hdl/pcgc_sync2.sv
`timescale 1ns/1ps
module pcgc_sync2
(
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;
    logic q_reg;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_reg <= 1'b0;
            q_reg    <= 1'b0;
        end
        else
        begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule : pcgc_sync2

// ===== hdl/pcgc_ctrl.sv
// Summary of operation
// R1 - Unit with run enable clear stays inactive; accesses get no answer.
// R2 - All run enables reset to cleared, so every peripheral starts disabled.
// R3 - Peripheral becomes active five clock cycles after its enabling write.
// R4 - Access during enable latency ends in a bus fault response.
// R5 - Bus master should not access a peripheral during its enable latency.
// R6 - Deep-sleep enable keeps a peripheral clocked while in deep sleep.
// R7 - Deep-sleep settings apply only with global gating set; otherwise kept.
// R8 - Timers and other rate-bound units are not left running in deep sleep.
// R9 - Read-only presence indication per peripheral for this variant.
// R10 - Units from converter to watchdog get enable and deep-sleep control.
// R11 - Each selectable peripheral has its own software reset.
// R12 - Software reset pulses the reset line briefly; unit stays enabled.
// R13 - With gating clear, sleep and deep sleep clock exactly as in run.
// R14 - Peripheral gated in deep sleep resumes with its state preserved.
// R15 - Each unit has its own latency counter, started by the enable write.
`timescale 1ns/1ps
module pcgc_ctrl
(
    input  wire logic                        ref_clk_i,
    input  wire logic                        rstn_i,
    input  wire pcgc_pkg::pcgc_cmd_t         cmd_i,
    input  wire logic                        gating_en_i,
    input  wire logic                        deep_sleep_i,
    input  wire pcgc_pkg::pcgc_acc_t         acc_i,
    output logic [pcgc_pkg::NUM_PERIPH-1:0]  clk_en_o,
    output logic [pcgc_pkg::NUM_PERIPH-1:0]  active_o,
    output logic [pcgc_pkg::NUM_PERIPH-1:0]  run_en_o,
    output logic [pcgc_pkg::NUM_PERIPH-1:0]  dsleep_en_o,
    output logic [pcgc_pkg::NUM_PERIPH-1:0]  present_o,
    output logic [pcgc_pkg::NUM_PERIPH-1:0]  periph_rst_o,
    output logic                             acc_ok_o,
    output logic                             acc_fault_o,
    output logic                             acc_ignored_o
);
    localparam int unsigned N = pcgc_pkg::NUM_PERIPH;

    function automatic logic [N-1:0] onehot
    (
        input logic [pcgc_pkg::SEL_W-1:0] sel
    );
        logic [N-1:0] v;
        v = pcgc_pkg::ALL_ZERO;
        // Selects above the last entry decode to nothing and are ignored.
        if (sel <= pcgc_pkg::LAST_SELECT)
        begin
            v[sel] = 1'b1;
        end
        return v;
    endfunction : onehot

    function automatic logic any_hit
    (
        input logic [N-1:0] a,
        input logic [N-1:0] b
    );
        return (a & b) != pcgc_pkg::ALL_ZERO;
    endfunction : any_hit

    // The sleep request is asynchronous to this logic.
    logic deep_sleep_s;
    pcgc_sync2 u_ds_sync
    (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .d_i       (deep_sleep_i),
        .q_o       (deep_sleep_s)
    );

    logic [N-1:0]                run_reg,    run_next;
    logic [N-1:0]                ds_reg,     ds_next;
    logic [pcgc_pkg::LAT_W-1:0]  lat_reg  [N];
    logic [pcgc_pkg::LAT_W-1:0]  lat_next [N];
    logic [pcgc_pkg::SRST_W-1:0] srst_reg [N];
    logic [pcgc_pkg::SRST_W-1:0] srst_next[N];
    logic [N-1:0]                act_reg,    act_next;
    logic [N-1:0]                clk_reg,    clk_next;
    logic [N-1:0]                rst_reg,    rst_next;
    logic                        ok_reg,     ok_next;
    logic                        flt_reg,    flt_next;
    logic                        ign_reg,    ign_next;

    always_comb
    begin
        logic [N-1:0] sel_hot;
        logic [N-1:0] acc_hot;
        sel_hot  = onehot(cmd_i.sel);
        acc_hot  = onehot(acc_i.sel);
        run_next = run_reg;
        ds_next  = ds_reg;
        ok_next  = 1'b0;
        flt_next = 1'b0;
        ign_next = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            lat_next[i]  = lat_reg[i];
            srst_next[i] = srst_reg[i];
            if (lat_reg[i] != pcgc_pkg::LAT_ZERO)
            begin
                lat_next[i] = lat_reg[i] - pcgc_pkg::LAT_ONE; // R15
            end
            if (srst_reg[i] != pcgc_pkg::SRST_ZERO)
            begin
                srst_next[i] = srst_reg[i] - pcgc_pkg::SRST_ONE; // R12
            end
            if (sel_hot[i])
            begin
                // An enable write to an already running unit does not refault.
                if (cmd_i.run_set && !run_reg[i])
                begin
                    run_next[i] = 1'b1;
                    lat_next[i] = pcgc_pkg::LAT_LOAD; // R3 R15
                end
                else if (cmd_i.run_clr && !cmd_i.run_set)
                begin
                    // A disable aborts any latency still running.
                    run_next[i] = 1'b0;
                    lat_next[i] = pcgc_pkg::LAT_ZERO;
                end
                if (cmd_i.dsleep_set)
                begin
                    ds_next[i] = 1'b1; // R6
                end
                else if (cmd_i.dsleep_clr)
                begin
                    ds_next[i] = 1'b0;
                end
                if (cmd_i.sw_reset)
                begin
                    srst_next[i] = pcgc_pkg::SRST_LOAD; // R11
                end
            end
            act_next[i] = run_next[i] && (lat_next[i] == pcgc_pkg::LAT_ZERO);
            rst_next[i] = srst_next[i] != pcgc_pkg::SRST_ZERO; // R12
            // Gating state is kept, so a stopped unit resumes intact.
            clk_next[i] = run_next[i] && !(gating_en_i && deep_sleep_s
                          && !ds_next[i]); // R7 R13 R14
        end
        // The answer uses the state at the access edge, so an access
        // that meets the enabling write is still refused.
        if (acc_i.valid)
        begin
            if (any_hit(acc_hot, act_reg))
            begin
                ok_next = 1'b1;
            end
            else if (any_hit(acc_hot, run_reg))
            begin
                flt_next = 1'b1; // R4
            end
            else
            begin
                ign_next = 1'b1; // R1
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            run_reg <= pcgc_pkg::ALL_ZERO; // R2
            ds_reg  <= pcgc_pkg::ALL_ZERO;
            act_reg <= pcgc_pkg::ALL_ZERO;
            clk_reg <= pcgc_pkg::ALL_ZERO;
            rst_reg <= pcgc_pkg::ALL_ZERO;
            ok_reg  <= 1'b0;
            flt_reg <= 1'b0;
            ign_reg <= 1'b0;
            for (int i = 0; i < N; i++)
            begin
                lat_reg[i]  <= pcgc_pkg::LAT_ZERO;
                srst_reg[i] <= pcgc_pkg::SRST_ZERO;
            end
        end
        else
        begin
            run_reg <= run_next;
            ds_reg  <= ds_next;
            act_reg <= act_next;
            clk_reg <= clk_next;
            rst_reg <= rst_next;
            ok_reg  <= ok_next;
            flt_reg <= flt_next;
            ign_reg <= ign_next;
            for (int i = 0; i < N; i++)
            begin
                lat_reg[i]  <= lat_next[i];
                srst_reg[i] <= srst_next[i];
            end
        end
    end

    // Presence is a constant of this variant, held in a flop for timing.
    logic [N-1:0] pres_reg;
    logic [N-1:0] pres_next;

    always_comb
    begin
        pres_next = pcgc_pkg::PRESENT_MASK; // R9 R10
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pres_reg <= pcgc_pkg::ALL_ZERO;
        end
        else
        begin
            pres_reg <= pres_next;
        end
    end

    assign run_en_o      = run_reg;
    assign dsleep_en_o   = ds_reg;
    assign active_o      = act_reg;
    assign clk_en_o      = clk_reg;
    assign periph_rst_o  = rst_reg;
    assign present_o     = pres_reg;
    assign acc_ok_o      = ok_reg;
    assign acc_fault_o   = flt_reg;
    assign acc_ignored_o = ign_reg;
endmodule : pcgc_ctrl

// ===== verif/pcgc_ctrl_asserts.sv
`timescale 1ns/1ps
module pcgc_ctrl_asserts
(
    input wire logic                ref_clk_i,
    input wire logic                rstn_i,
    input wire pcgc_pkg::pcgc_cmd_t cmd_i,
    input wire logic                gating_en_i,
    input wire logic                deep_sleep_i,
    input wire pcgc_pkg::pcgc_acc_t acc_i,
    input wire logic [24:0]         clk_en_o,
    input wire logic [24:0]         active_o,
    input wire logic [24:0]         run_en_o,
    input wire logic [24:0]         dsleep_en_o,
    input wire logic [24:0]         present_o,
    input wire logic [24:0]         periph_rst_o,
    input wire logic                acc_ok_o,
    input wire logic                acc_fault_o,
    input wire logic                acc_ignored_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_rst;
        $rose(rstn_i) |-> run_en_o == pcgc_pkg::ALL_ZERO;
    endproperty
    a_rst: assert property (p_rst) else $error("enables set");

    property p_ign;
        acc_i.valid && !run_en_o[acc_i.sel]
            |=> acc_ignored_o && !acc_fault_o;
    endproperty
    a_ign: assert property (p_ign) else $error("not ignored");

    // The write edge and five counting edges pass before the unit answers.
    property p_lat;
        cmd_i.run_set && cmd_i.sel == 5'h03 && !run_en_o[3]
            |=> !active_o[3] [*5] ##1 active_o[3];
    endproperty
    a_lat: assert property (p_lat) else $error("latency");

    property p_flt;
        acc_i.valid && run_en_o[acc_i.sel] && !active_o[acc_i.sel]
            |=> acc_fault_o;
    endproperty
    a_flt: assert property (p_flt) else $error("no fault");

    property p_ok;
        acc_i.valid && active_o[acc_i.sel]
            |=> acc_ok_o && !acc_fault_o && !acc_ignored_o;
    endproperty
    a_ok: assert property (p_ok) else $error("no answer");

    property p_srst;
        cmd_i.sw_reset && cmd_i.sel == 5'h07
            |=> periph_rst_o[7] [*2] ##1 !periph_rst_o[7];
    endproperty
    a_srst: assert property (p_srst) else $error("pulse");

    property p_run;
        !gating_en_i |=> clk_en_o == run_en_o;
    endproperty
    a_run: assert property (p_run) else $error("clock");

    property p_gate;
        (gating_en_i && deep_sleep_i && run_en_o[3] && !dsleep_en_o[3]) [*4]
            |-> !clk_en_o[3];
    endproperty
    a_gate: assert property (p_gate) else $error("gating");

    // Presence loads at the first edge after release, so that edge is skipped.
    property p_pres;
        $past(rstn_i) |-> present_o == pcgc_pkg::PRESENT_MASK;
    endproperty
    a_pres: assert property (p_pres) else $error("presence");
endmodule : pcgc_ctrl_asserts
bind pcgc_ctrl pcgc_ctrl_asserts u_pcgc_ctrl_asserts
(
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i), .acc_i(acc_i),
    .gating_en_i(gating_en_i), .deep_sleep_i(deep_sleep_i),
    .clk_en_o(clk_en_o), .active_o(active_o), .run_en_o(run_en_o),
    .dsleep_en_o(dsleep_en_o), .present_o(present_o),
    .periph_rst_o(periph_rst_o), .acc_ok_o(acc_ok_o),
    .acc_fault_o(acc_fault_o), .acc_ignored_o(acc_ignored_o)
);

// ===== verif/pcgc_core_model.sv
`timescale 1ns/1ps
module pcgc_core_model
(
    input  wire logic           ref_clk_i,
    output pcgc_pkg::pcgc_cmd_t cmd_o,
    output pcgc_pkg::pcgc_acc_t acc_o
);
    initial cmd_o = 10'h000;
    initial acc_o = 7'h00;
    // One request a cycle, so a command and an access never collide.
    task cmd(input logic [4:0] kind, input logic [4:0] sel);
        cmd_o <= {kind, sel};
        acc_o <= 7'h00;
        @(negedge ref_clk_i);
    endtask : cmd
    // Early accesses are made only where a test wants the fault.
    task acc(input logic v, input logic [4:0] sel);
        acc_o <= {v, 1'b0, sel};
        cmd_o <= 10'h000;
        @(negedge ref_clk_i);
    endtask : acc
endmodule : pcgc_core_model

// ===== verif/test_pcgc_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, s) \
    begin \
        cmp_count++; \
        if ((s) !== (e)) \
        begin \
            errors++; \
            $display("mismatch %s exp %h got %h", n, e, s); \
        end \
    end
module test_pcgc_ctrl;
    localparam logic [4:0] RUN = 5'h10;
    localparam logic [4:0] CLR = 5'h08;
    localparam logic [4:0] DSET = 5'h04;
    localparam logic [4:0] SRST = 5'h01;
    localparam logic [4:0] DCLR = 5'h02;
    logic                ref_clk_i = 1'b0;
    logic                rstn_i = 1'b0;
    logic                gating_en_i = 1'b0;
    logic                deep_sleep_i = 1'b0;
    pcgc_pkg::pcgc_cmd_t cmd_i;
    pcgc_pkg::pcgc_acc_t acc_i;
    logic [24:0]         clk_en_o, active_o, run_en_o, dsleep_en_o;
    logic [24:0]         present_o, periph_rst_o, exp_run;
    logic                acc_ok_o, acc_fault_o, acc_ignored_o;
    int                  errors = 0;
    int                  cmp_count = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    pcgc_core_model u_pcgc_core_model
    (
        .ref_clk_i(ref_clk_i), .cmd_o(cmd_i), .acc_o(acc_i)
    );
    pcgc_ctrl u_pcgc_ctrl
    (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i),
        .gating_en_i(gating_en_i), .deep_sleep_i(deep_sleep_i),
        .acc_i(acc_i), .clk_en_o(clk_en_o), .active_o(active_o),
        .run_en_o(run_en_o), .dsleep_en_o(dsleep_en_o),
        .present_o(present_o), .periph_rst_o(periph_rst_o),
        .acc_ok_o(acc_ok_o), .acc_fault_o(acc_fault_o),
        .acc_ignored_o(acc_ignored_o)
    );
    task test_done;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // The tests need some 60 cycles; this limit leaves a wide margin.
    initial
    begin
        #50000;
        errors++;
        test_done();
    end
    initial
    begin
        repeat (8) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        @(negedge ref_clk_i);
        `CHK("run_en", 25'h0000000, run_en_o)
        `CHK("present", pcgc_pkg::PRESENT_MASK, present_o)
        u_pcgc_core_model.acc(1'b1, 5'h03);
        `CHK("ignored", 1'b1, acc_ignored_o)
        u_pcgc_core_model.cmd(RUN, 5'h03);
        `CHK("run_en3", 1'b1, run_en_o[3])
        // Accesses at the five edges after the enabling write all fault.
        for (int i = 0; i < 5; i++)
        begin
            u_pcgc_core_model.acc(1'b1, 5'h03);
            `CHK("fault", 1'b1, acc_fault_o)
        end
        u_pcgc_core_model.acc(1'b1, 5'h03);
        `CHK("ok", 1'b1, acc_ok_o)
        `CHK("active3", 1'b1, active_o[3])
        exp_run = 25'h0000008;
        for (int i = 0; i < 24; i++)
        begin
            u_pcgc_core_model.cmd(RUN, i[4:0]);
            exp_run[i] = 1'b1;
            `CHK("run_en", exp_run, run_en_o)
        end
        u_pcgc_core_model.cmd(SRST, 5'h07);
        `CHK("prst", 25'h0000080, periph_rst_o)
        u_pcgc_core_model.acc(1'b0, 5'h00);
        `CHK("prst", 25'h0000080, periph_rst_o)
        u_pcgc_core_model.acc(1'b0, 5'h00);
        `CHK("prst", 25'h0000000, periph_rst_o)
        `CHK("run_en", exp_run, run_en_o)
        deep_sleep_i = 1'b1;
        repeat (4) u_pcgc_core_model.acc(1'b0, 5'h00);
        `CHK("clk_en", exp_run, clk_en_o)
        gating_en_i = 1'b1;
        // Only a port unit is kept in deep sleep; timers would see a new rate.
        u_pcgc_core_model.cmd(DSET, 5'h05);
        repeat (3) u_pcgc_core_model.acc(1'b0, 5'h00);
        `CHK("clk_en", 25'h0000020, clk_en_o)
        `CHK("dsleep_en", 25'h0000020, dsleep_en_o)
        deep_sleep_i = 1'b0;
        repeat (4) u_pcgc_core_model.acc(1'b0, 5'h00);
        `CHK("clk_en", exp_run, clk_en_o)
        `CHK("active", exp_run, active_o)
        u_pcgc_core_model.cmd(DCLR, 5'h05);
        `CHK("dsleep_en", 25'h0000000, dsleep_en_o)
        `CHK("clk_en", exp_run, clk_en_o)
        u_pcgc_core_model.cmd(CLR, 5'h03);
        `CHK("run_en3", 1'b0, run_en_o[3])
        u_pcgc_core_model.acc(1'b1, 5'h03);
        `CHK("ignored", 1'b1, acc_ignored_o)
        u_pcgc_core_model.acc(1'b0, 5'h00);
        test_done();
    end
endmodule : test_pcgc_ctrl
